/* verilog/sae_defines.svh */
// Constants for the scan channel alarm evaluator: offsets, fields, command codes, sizes.
// Assumes a 32-bit APB master on the same 100 MHz clock.
// Functional notes
// - Four shared alert outputs, numbered one to four
// - Scan reading beyond limit raises assigned alert
// - Scanned alarm goes to reading store and queue
// - Non-scanned alarm goes to queue only
// - One alert output and limit per channel
// - Digital and totalizer alarms work outside scan
// - Mode set restricted by channel kind
// - Window mode: above upper or below lower
// - High mode: strictly above upper limit
// - Low mode: strictly below lower limit
// - Totalizer upper limit is full unsigned 32-bit
// - Window mode rejects upper below lower
// - Digital alarm on match or mismatch
// - Digital value width 8, 16 or 32
// - Oversized digital value rejected with error
// - Masked bits excluded from digital compare
// - Config change or scaling clears alarm, limits
// - Analog channel off scan list: no evaluation, limits kept
// - Back on scan list: evaluation resumes
`ifndef SAE_DEFINES_SVH
`define SAE_DEFINES_SVH

// ==========================================================================
// Register map (byte addresses)
`define SAE_ADDR_SEL      12'h000
`define SAE_ADDR_CFG      12'h004
`define SAE_ADDR_UPPER    12'h008
`define SAE_ADDR_LOWER    12'h00c
`define SAE_ADDR_MASK     12'h010
`define SAE_ADDR_COMMIT   12'h014
`define SAE_ADDR_STATUS   12'h018
`define SAE_ADDR_QCHAN    12'h01c
`define SAE_ADDR_QDATA    12'h020
`define SAE_ADDR_EVENT    12'h024

// ==========================================================================
// Field layout of the configuration word
`define SAE_CFG_MODE_LSB  0
`define SAE_CFG_OUT_LSB   2
`define SAE_CFG_KIND_LSB  4
`define SAE_CFG_WID_LSB   6
`define SAE_CFG_COND_BIT  8
`define SAE_CFG_SCAN_BIT  9

// Commit and event command codes
`define SAE_CMD_WRITE     2'h1
`define SAE_CMD_RECONF    2'h2

// Sizes
`define SAE_NCHAN         8
`define SAE_QDEPTH        8
`define SAE_CH_W          3
`define SAE_Q_W           3

`endif

/* verilog/sae_pkg.sv */
// Types for the scan channel alarm evaluator.
// Assumes sae_defines.svh is included where constants are needed.
package sae_pkg;
  // Alarm mode; digital uses none/high as off/on
  typedef enum logic [1:0] {SAE_NONE, SAE_HIGH, SAE_LOW, SAE_WINDOW} sae_mode_t;
  // Channel kind
  typedef enum logic [1:0] {SAE_ANALOG, SAE_DIGITAL, SAE_TOTAL} sae_kind_t;
  // Digital word width
  typedef enum logic [1:0] {SAE_W8, SAE_W16, SAE_W32} sae_wid_t;
endpackage

/* verilog/sae_alarm_evaluator.sv */
// Alarm evaluator: per-channel limits, four alert outputs, alarm queue.
// Assumes readings and APB arrive on sys_clk; reset is synchronous.
//
// The placing of the registers and register access over APB are this design's own decisions.
`include "sae_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module sae_alarm_evaluator (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rd_valid,
  input wire logic [2:0] rd_chan,
  input wire logic [31:0] rd_value,
  input wire logic rd_scanned,
  output logic alert_output_one,
  output logic alert_output_two,
  output logic alert_output_three,
  output logic alert_output_four,
  output logic store_valid,
  output logic [2:0] store_chan,
  output logic [31:0] store_value,
  output logic store_alarm,
  output logic [1:0] store_alert_idx
);

  // ========================================================================
  // Per-channel settings
  sae_pkg::sae_mode_t mode_q [`SAE_NCHAN]; // Alarm mode
  logic [1:0] out_q [`SAE_NCHAN]; // Alert output index
  sae_pkg::sae_kind_t kind_q [`SAE_NCHAN]; // Channel kind
  sae_pkg::sae_wid_t wid_q [`SAE_NCHAN]; // Digital width
  logic cond_q [`SAE_NCHAN]; // 1 = match alarms
  logic scan_q [`SAE_NCHAN]; // Scan list member
  logic [31:0] upper_q [`SAE_NCHAN]; // Upper limit / digital value
  logic [31:0] lower_q [`SAE_NCHAN]; // Lower limit
  logic [31:0] mask_q [`SAE_NCHAN]; // Don't-care bits
  // Staging registers for a commit
  logic [2:0] sel_q;
  logic [9:0] cfg_stage_q;
  logic [31:0] upper_stage_q;
  logic [31:0] lower_stage_q;
  logic [31:0] mask_stage_q;
  logic err_q; // Sticky reject flag
  // Queue storage
  logic [2:0] qchan_q [`SAE_QDEPTH];
  logic [1:0] qidx_q [`SAE_QDEPTH];
  logic [31:0] qval_q [`SAE_QDEPTH];
  logic [`SAE_Q_W-1:0] qwr_q;
  logic [`SAE_Q_W-1:0] qrd_q;
  logic [`SAE_Q_W:0] qcnt_q;
  logic qovf_q;

  // ========================================================================
  // Helpers
  // Value fits the configured digital width
  function automatic logic fits(input sae_pkg::sae_wid_t w, input logic [31:0] v);
    case (w)
      sae_pkg::SAE_W8: fits = (v[31:8] == 24'h000000);
      sae_pkg::SAE_W16: fits = (v[31:16] == 16'h0000);
      default: fits = 1'b1;
    endcase
  endfunction

  // Signed compare a > b for analog readings
  function automatic logic sgt(input logic [31:0] a, input logic [31:0] b);
    sgt = ($signed(a) > $signed(b));
  endfunction

  // ========================================================================
  // APB decode
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic commit_ok;
  sae_pkg::sae_mode_t st_mode;
  sae_pkg::sae_kind_t st_kind;
  sae_pkg::sae_wid_t st_wid;
  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && penable && !pwrite && pready;
  assign st_mode = sae_pkg::sae_mode_t'(cfg_stage_q[`SAE_CFG_MODE_LSB +: 2]);
  assign st_kind = sae_pkg::sae_kind_t'(cfg_stage_q[`SAE_CFG_KIND_LSB +: 2]);
  assign st_wid = sae_pkg::sae_wid_t'(cfg_stage_q[`SAE_CFG_WID_LSB +: 2]);

  // Address decoding
  always_comb begin
    if (paddr == `SAE_ADDR_SEL) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_CFG) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_UPPER) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_LOWER) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_MASK) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_COMMIT) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_STATUS) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_QCHAN) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_QDATA) addr_ok = 1'b1;
    else if (paddr == `SAE_ADDR_EVENT) addr_ok = 1'b1;
    else addr_ok = 1'b0;
  end

  // Commit legality: mode per kind, window order, digital width
  always_comb begin
    commit_ok = 1'b1;
    if (st_kind == sae_pkg::SAE_DIGITAL) begin
      commit_ok = (st_mode == sae_pkg::SAE_NONE) || (st_mode == sae_pkg::SAE_HIGH);
      if (!fits(st_wid, upper_stage_q)) commit_ok = 1'b0;
    end else if (st_kind == sae_pkg::SAE_TOTAL) begin
      // Full unsigned range accepted for the count limit
      commit_ok = (st_mode == sae_pkg::SAE_NONE) || (st_mode == sae_pkg::SAE_HIGH);
    end else if (st_mode == sae_pkg::SAE_WINDOW) begin
      commit_ok = !sgt(lower_stage_q, upper_stage_q);
    end
    if (st_kind == sae_pkg::SAE_DIGITAL && st_wid == 2'h3) commit_ok = 1'b0;
  end

  // ========================================================================
  // Bus slave: no wait state, so pready rises on the access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Error answer for unmapped addresses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // Staging registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sel_q <= 3'h0;
      cfg_stage_q <= 10'h000;
      upper_stage_q <= 32'h00000000;
      lower_stage_q <= 32'h00000000;
      mask_stage_q <= 32'h00000000;
    end else if (apb_wr) begin
      if (paddr == `SAE_ADDR_SEL) sel_q <= pwdata[2:0];
      else if (paddr == `SAE_ADDR_CFG) cfg_stage_q <= pwdata[9:0];
      else if (paddr == `SAE_ADDR_UPPER) upper_stage_q <= pwdata;
      else if (paddr == `SAE_ADDR_LOWER) lower_stage_q <= pwdata;
      else if (paddr == `SAE_ADDR_MASK) mask_stage_q <= pwdata;
    end
  end

  // Channel tables: commit, reconfigure event, scan membership
  logic do_commit;
  logic do_reconf;
  assign do_commit = apb_wr && paddr == `SAE_ADDR_COMMIT && pwdata[1:0] == `SAE_CMD_WRITE;
  assign do_reconf = apb_wr && paddr == `SAE_ADDR_EVENT && pwdata[1:0] == `SAE_CMD_RECONF;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `SAE_NCHAN; i++) begin
        mode_q[i] <= sae_pkg::SAE_NONE;
        out_q[i] <= 2'h0;
        kind_q[i] <= sae_pkg::SAE_ANALOG;
        wid_q[i] <= sae_pkg::SAE_W8;
        cond_q[i] <= 1'b0;
        scan_q[i] <= 1'b0;
        upper_q[i] <= 32'h00000000;
        lower_q[i] <= 32'h00000000;
        mask_q[i] <= 32'h00000000;
      end
    end else if (do_reconf) begin
      // Measurement change or scaling on: alarm off, limits cleared
      mode_q[sel_q] <= sae_pkg::SAE_NONE;
      upper_q[sel_q] <= 32'h00000000;
      lower_q[sel_q] <= 32'h00000000;
      mask_q[sel_q] <= 32'h00000000;
    end else if (do_commit && commit_ok) begin
      // One output and one limit set per channel
      mode_q[sel_q] <= st_mode;
      out_q[sel_q] <= cfg_stage_q[`SAE_CFG_OUT_LSB +: 2];
      kind_q[sel_q] <= st_kind;
      wid_q[sel_q] <= st_wid;
      cond_q[sel_q] <= cfg_stage_q[`SAE_CFG_COND_BIT];
      scan_q[sel_q] <= cfg_stage_q[`SAE_CFG_SCAN_BIT];
      upper_q[sel_q] <= upper_stage_q;
      lower_q[sel_q] <= lower_stage_q;
      mask_q[sel_q] <= mask_stage_q;
    end else if (apb_wr && paddr == `SAE_ADDR_CFG && pwdata[31]) begin
      // Scan list membership only; limits retained either way
      scan_q[sel_q] <= pwdata[`SAE_CFG_SCAN_BIT];
    end
  end

  // Sticky reject flag; a new reject wins over the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      err_q <= 1'b0;
    end else if (do_commit && !commit_ok) begin
      err_q <= 1'b1;
    end else if (apb_wr && paddr == `SAE_ADDR_STATUS && pwdata[0]) begin
      err_q <= 1'b0;
    end
  end

  // ========================================================================
  // Evaluation of one delivered reading
  logic hit;
  logic eligible;
  logic [2:0] ch;
  assign ch = rd_chan;
  always_comb begin
    hit = 1'b0;
    case (kind_q[ch])
      sae_pkg::SAE_DIGITAL: begin
        if (mode_q[ch] != sae_pkg::SAE_NONE) begin
          // Masked bits ignored; cond picks match or mismatch
          hit = (((rd_value ^ upper_q[ch]) & ~mask_q[ch]) == 32'h00000000) == cond_q[ch];
        end
      end
      sae_pkg::SAE_TOTAL: begin
        hit = (mode_q[ch] == sae_pkg::SAE_HIGH) && (rd_value > upper_q[ch]);
      end
      default: begin
        case (mode_q[ch])
          sae_pkg::SAE_HIGH: hit = sgt(rd_value, upper_q[ch]);
          sae_pkg::SAE_LOW: hit = sgt(lower_q[ch], rd_value);
          sae_pkg::SAE_WINDOW: hit = sgt(rd_value, upper_q[ch]) || sgt(lower_q[ch], rd_value);
          default: hit = 1'b0;
        endcase
      end
    endcase
  end
  // Analog needs scan membership; digital/total always evaluate
  assign eligible = rd_valid && (scan_q[ch] || kind_q[ch] != sae_pkg::SAE_ANALOG);

  // Alert outputs: one-cycle pulse on the assigned output
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alert_output_one <= 1'b0;
      alert_output_two <= 1'b0;
      alert_output_three <= 1'b0;
      alert_output_four <= 1'b0;
    end else begin
      alert_output_one <= eligible && hit && out_q[ch] == 2'h0;
      alert_output_two <= eligible && hit && out_q[ch] == 2'h1;
      alert_output_three <= eligible && hit && out_q[ch] == 2'h2;
      alert_output_four <= eligible && hit && out_q[ch] == 2'h3;
    end
  end

  // Reading store port: scanned readings only, alarm flag beside
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      store_valid <= 1'b0;
      store_chan <= 3'h0;
      store_value <= 32'h00000000;
      store_alarm <= 1'b0;
      store_alert_idx <= 2'h0;
    end else begin
      store_valid <= rd_valid && rd_scanned;
      store_chan <= rd_chan;
      store_value <= rd_value;
      store_alarm <= eligible && hit && rd_scanned;
      store_alert_idx <= out_q[ch];
    end
  end

  // ========================================================================
  // Alarm queue: every alarm, scanned or not; drops when full
  logic q_push;
  logic q_pop;
  assign q_push = eligible && hit && qcnt_q != 4'(`SAE_QDEPTH);
  assign q_pop = apb_rd && paddr == `SAE_ADDR_QDATA && qcnt_q != 4'h0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      qwr_q <= 3'h0;
    end else if (q_push) begin
      qchan_q[qwr_q] <= rd_chan;
      qval_q[qwr_q] <= rd_value;
      qidx_q[qwr_q] <= out_q[ch];
      qwr_q <= qwr_q + 3'h1;
    end
  end

  // Read pointer and fill count, arrival order kept
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      qrd_q <= 3'h0;
      qcnt_q <= 4'h0;
    end else begin
      if (q_pop) qrd_q <= qrd_q + 3'h1;
      qcnt_q <= qcnt_q + 4'(q_push) - 4'(q_pop);
    end
  end

  // Overflow flag; new overflow wins over the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      qovf_q <= 1'b0;
    end else if (eligible && hit && qcnt_q == 4'(`SAE_QDEPTH)) begin
      qovf_q <= 1'b1;
    end else if (apb_wr && paddr == `SAE_ADDR_STATUS && pwdata[1]) begin
      qovf_q <= 1'b0;
    end
  end

  // Read data, registered for the access cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      if (paddr == `SAE_ADDR_SEL) prdata <= {29'h0, sel_q};
      else if (paddr == `SAE_ADDR_CFG) prdata <= {22'h0, scan_q[sel_q], cond_q[sel_q],
        wid_q[sel_q], kind_q[sel_q], out_q[sel_q], mode_q[sel_q]};
      else if (paddr == `SAE_ADDR_UPPER) prdata <= upper_q[sel_q];
      else if (paddr == `SAE_ADDR_LOWER) prdata <= lower_q[sel_q];
      else if (paddr == `SAE_ADDR_MASK) prdata <= mask_q[sel_q];
      else if (paddr == `SAE_ADDR_STATUS) prdata <= {24'h0, qcnt_q, 2'h0, qovf_q, err_q};
      else if (paddr == `SAE_ADDR_QCHAN) prdata <= {27'h0, qidx_q[qrd_q], qchan_q[qrd_q]};
      else if (paddr == `SAE_ADDR_QDATA) prdata <= qval_q[qrd_q];
      else prdata <= 32'h00000000;
    end
  end

  // ========================================================================
  // Checks
  chk_high_fires: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (eligible && kind_q[ch] == sae_pkg::SAE_ANALOG && mode_q[ch] == sae_pkg::SAE_HIGH
     && sgt(rd_value, upper_q[ch])) |=> ({alert_output_four, alert_output_three,
     alert_output_two, alert_output_one} == (4'h1 << $past(out_q[ch]))))
    else $error("high alarm missed");
  chk_one_eval: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rd_valid |=> !(alert_output_one || alert_output_two || alert_output_three
     || alert_output_four || store_valid))
    else $error("output without a reading");
  chk_low_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_valid && mode_q[ch] == sae_pkg::SAE_LOW && kind_q[ch] == sae_pkg::SAE_ANALOG
     && !sgt(lower_q[ch], rd_value)) |=> !store_alarm)
    else $error("low alarm spurious");
  chk_window_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (do_commit && st_kind == sae_pkg::SAE_ANALOG && st_mode == sae_pkg::SAE_WINDOW
     && sgt(lower_stage_q, upper_stage_q)) |=> err_q)
    else $error("window order not rejected");
  chk_width_reject: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (do_commit && st_kind == sae_pkg::SAE_DIGITAL && st_wid == sae_pkg::SAE_W8
     && upper_stage_q[8]) |=> (err_q && $stable(upper_q[sel_q])))
    else $error("wide digital value stored");
  chk_reconf_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    do_reconf |=> (mode_q[$past(sel_q)] == sae_pkg::SAE_NONE && upper_q[$past(sel_q)] == 32'h0))
    else $error("reconfigure did not clear");
  chk_unscanned_silent: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_valid && !scan_q[ch] && kind_q[ch] == sae_pkg::SAE_ANALOG) |=> !store_alarm)
    else $error("off-list channel evaluated");
  chk_store_scanned: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (rd_valid && !rd_scanned) |=> !store_valid)
    else $error("non-scanned reading stored");
  chk_queue_push: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q_push && !q_pop) |=> qcnt_q == $past(qcnt_q) + 4'h1)
    else $error("queue count wrong");
  chk_apb_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && !penable) |=> pready)
    else $error("bus answer late");
  cov_scan_alarm: cover property (@(posedge sys_clk) store_alarm);
  cov_digital_alarm: cover property (@(posedge sys_clk)
    eligible && hit && kind_q[ch] == sae_pkg::SAE_DIGITAL);
  cov_queue_full: cover property (@(posedge sys_clk) qovf_q);
  cov_reject: cover property (@(posedge sys_clk) err_q);

endmodule // sae_alarm_evaluator

`default_nettype wire

/* tb/sae_reading_src.sv */
// Reading source standing in for the scan and measurement engine.
// Assumes one bench process calls send() and that sys_clk is running.
`timescale 1ns/100ps
`default_nettype none

module sae_reading_src (
  input wire logic sys_clk,
  output logic rd_valid,
  output logic [2:0] rd_chan,
  output logic [31:0] rd_value,
  output logic rd_scanned
);
  // ==========================================================================
  // Idle values at time zero
  initial begin
    rd_valid = 1'b0;
    rd_chan = 3'h0;
    rd_value = 32'h0;
    rd_scanned = 1'b0;
  end

  // ==========================================================================
  // One reading per call; a gap of idle cycles models a slow engine
  task automatic send(input logic [2:0] ch, input logic [31:0] v, input logic sc, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    rd_valid <= 1'b1;
    rd_chan <= ch;
    rd_value <= v;
    rd_scanned <= sc;
    @(posedge sys_clk);
    // Released lines show the inverse, so stale values never pass as data
    rd_valid <= 1'b0;
    rd_chan <= ~ch;
    rd_value <= ~v;
    rd_scanned <= ~sc;
  endtask
endmodule // sae_reading_src
`default_nettype wire

/* tb/sae_alarm_evaluator_tb.sv */
// Self-checking bench for the alarm evaluator: APB master, reading source.
// Assumes sae_defines.svh on the include path and the design compiled first.
`include "sae_defines.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module sae_alarm_evaluator_tb;
  // ==========================================================================
  // Signals
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic rd_valid, rd_scanned;
  wire logic [2:0] rd_chan;
  wire logic [31:0] rd_value;
  wire logic [3:0] alerts;
  logic store_valid, store_alarm;
  logic [2:0] store_chan;
  logic [31:0] store_value;
  logic [1:0] store_alert_idx;
  int failures = 0;
  int checks_done = 0;
  int seed = 74;
  logic [31:0] v;
  logic [33:0] apb_q[$]; // Each transfer: {write, error, data}
  logic [1:0] alert_q[$]; // Alert index per alarm reading
  logic [37:0] store_q[$]; // {chan, value, alarm, index}
  logic [36:0] alarm_q[$]; // {index, chan, value} in arrival order

  always #5 sys_clk = ~sys_clk;

  sae_alarm_evaluator dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid), .rd_chan(rd_chan),
    .rd_value(rd_value), .rd_scanned(rd_scanned), .alert_output_one(alerts[0]),
    .alert_output_two(alerts[1]), .alert_output_three(alerts[2]),
    .alert_output_four(alerts[3]), .store_valid(store_valid), .store_chan(store_chan),
    .store_value(store_value), .store_alarm(store_alarm), .store_alert_idx(store_alert_idx));

  sae_reading_src src_u (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_chan(rd_chan),
    .rd_value(rd_value), .rd_scanned(rd_scanned));

  // ==========================================================================
  // Closing task
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // APB transfer; expectation noted before the request goes out
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
    int n;
    n = 0;
    apb_q.push_back({wr, e, d});
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    // No latency assumed; pready is sampled at rising edges only
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 1'b0);
  endtask

  // Configuration word: {scan, cond, width, kind, output, mode}
  function automatic logic [31:0] cw(input logic [1:0] m, o, k, w, input logic c, s);
    return {22'h0, s, c, w, k, o, m};
  endfunction

  // Stage all settings of one channel and commit them
  task automatic cfg(input logic [2:0] ch, input logic [31:0] c, up, lo, mk);
    wr(`SAE_ADDR_SEL, {29'h0, ch});
    wr(`SAE_ADDR_CFG, c);
    wr(`SAE_ADDR_UPPER, up);
    wr(`SAE_ADDR_LOWER, lo);
    wr(`SAE_ADDR_MASK, mk);
    wr(`SAE_ADDR_COMMIT, 32'h1);
  endtask

  // One reading with its expected alert, store entry and queue entry
  task automatic rdg(input logic [2:0] ch, input logic [31:0] val, input logic sc, al,
                     input logic [1:0] ix);
    if (al) begin
      alert_q.push_back(ix);
      alarm_q.push_back({ix, ch, val});
    end
    if (sc) store_q.push_back({ch, val, al, ix});
    src_u.send(ch, val, sc, {$random(seed)} % 3);
  endtask

  // Empty the alarm queue, checking count and every entry
  task automatic drain();
    logic [36:0] e;
    rd(`SAE_ADDR_STATUS, {24'h0, 4'(alarm_q.size()), 4'h0});
    while (alarm_q.size() > 0) begin
      e = alarm_q.pop_front();
      rd(`SAE_ADDR_QCHAN, {27'h0, e[36:32]});
      rd(`SAE_ADDR_QDATA, e[31:0]);
    end
  endtask

  task automatic err_clear();
    // Queue fill shows in the same word as the error flag
    rd(`SAE_ADDR_STATUS, {24'h0, 4'(alarm_q.size()), 4'h1});
    wr(`SAE_ADDR_STATUS, 32'h1);
  endtask

  // ==========================================================================
  // Monitor: oldest note is taken off whenever a result shows
  always @(negedge sys_clk) begin
    logic [33:0] a;
    logic [37:0] s;
    logic [1:0] ix;
    if (sys_rst === 1'b0) begin
      if (psel && penable && pready === 1'b1) begin
        a = apb_q.pop_front();
        `CHK("pslverr", a[32], pslverr)
        if (!a[33]) `CHK("prdata", a[31:0], prdata)
      end
      if (alerts !== 4'h0) begin
        // Pop once; the macro uses its expected value twice
        ix = alert_q.pop_front();
        `CHK("alert", 4'h1 << ix, alerts)
      end
      if (store_valid !== 1'b0) begin
        s = store_q.pop_front();
        `CHK("store", s, {store_chan, store_value, store_alarm, s[2] ? store_alert_idx : s[1:0]})
      end
    end
  end

  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("BAD watchdog expired");
    final_report();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    `CHK("idle", 7'h0, {alerts, store_valid, pready, pslverr})
    rd(`SAE_ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0, 1'b1);
    $display("test reset done");
    // High mode on analog channel two, boundary then one above
    cfg(3'h2, cw(2'h1, 2'h1, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1), 32'd100, 32'h0, 32'h0);
    rd(`SAE_ADDR_UPPER, 32'd100);
    rdg(3'h2, 32'd100, 1'b1, 1'b0, 2'h0);
    rdg(3'h2, 32'd101, 1'b1, 1'b1, 2'h1);
    rdg(3'h2, 32'd101, 1'b0, 1'b1, 2'h1);
    drain();
    $display("test high done");
    // Low and window modes, signed boundaries and random in-window readings
    cfg(3'h3, cw(2'h2, 2'h2, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1), 32'h0, 32'hfffffffb, 32'h0);
    rdg(3'h3, 32'hfffffffb, 1'b1, 1'b0, 2'h0);
    rdg(3'h3, 32'hfffffffa, 1'b1, 1'b1, 2'h2);
    cfg(3'h4, cw(2'h3, 2'h3, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1), 32'd10, 32'hfffffff6, 32'h0);
    rdg(3'h4, 32'd11, 1'b1, 1'b1, 2'h3);
    rdg(3'h4, 32'hfffffff5, 1'b1, 1'b1, 2'h3);
    rdg(3'h4, 32'd10, 1'b1, 1'b0, 2'h0);
    rdg(3'h4, 32'hfffffff6, 1'b1, 1'b0, 2'h0);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) % 10;
      rdg(3'h4, v, 1'b1, 1'b0, 2'h0);
    end
    drain();
    // Upper below lower refused, old limits stay; equal limits accepted
    cfg(3'h4, cw(2'h3, 2'h3, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1), 32'hfffffff5, 32'hfffffff6, 32'h0);
    err_clear();
    rdg(3'h4, 32'd11, 1'b1, 1'b1, 2'h3);
    cfg(3'h4, cw(2'h3, 2'h3, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1), 32'd5, 32'd5, 32'h0);
    rdg(3'h4, 32'd6, 1'b1, 1'b1, 2'h3);
    drain();
    $display("test window done");
    // Digital channel outside the scan list, masked match then mismatch
    cfg(3'h5, cw(2'h1, 2'h0, sae_pkg::SAE_DIGITAL, 2'h0, 1'b1, 1'b0), 32'ha5, 32'h0, 32'h0f);
    rdg(3'h5, 32'ha0, 1'b0, 1'b1, 2'h0);
    rdg(3'h5, 32'hb5, 1'b0, 1'b0, 2'h0);
    cfg(3'h5, cw(2'h1, 2'h0, sae_pkg::SAE_DIGITAL, 2'h0, 1'b0, 1'b0), 32'ha5, 32'h0, 32'h0f);
    rdg(3'h5, 32'hb5, 1'b0, 1'b1, 2'h0);
    rdg(3'h5, 32'ha3, 1'b0, 1'b0, 2'h0);
    cfg(3'h5, cw(2'h1, 2'h0, sae_pkg::SAE_DIGITAL, 2'h0, 1'b1, 1'b0), 32'h1a5, 32'h0, 32'h0);
    err_clear();
    cfg(3'h5, cw(2'h2, 2'h0, sae_pkg::SAE_DIGITAL, 2'h1, 1'b1, 1'b0), 32'h1a5, 32'h0, 32'h0);
    err_clear();
    cfg(3'h5, cw(2'h1, 2'h0, sae_pkg::SAE_DIGITAL, 2'h1, 1'b1, 1'b0), 32'h1a5, 32'h0, 32'h0);
    rdg(3'h5, 32'h1a5, 1'b0, 1'b1, 2'h0);
    drain();
    $display("test digital done");
    // Totalizer: full unsigned upper limit, low mode refused
    cfg(3'h6, cw(2'h1, 2'h2, sae_pkg::SAE_TOTAL, 2'h0, 1'b0, 1'b0), 32'hffffffff, 32'h0, 32'h0);
    rdg(3'h6, 32'hffffffff, 1'b1, 1'b0, 2'h0);
    cfg(3'h6, cw(2'h1, 2'h2, sae_pkg::SAE_TOTAL, 2'h0, 1'b0, 1'b0), 32'hfffffffe, 32'h0, 32'h0);
    rdg(3'h6, 32'hffffffff, 1'b1, 1'b1, 2'h2);
    cfg(3'h6, cw(2'h2, 2'h2, sae_pkg::SAE_TOTAL, 2'h0, 1'b0, 1'b0), 32'h0, 32'h0, 32'h0);
    err_clear();
    drain();
    $display("test totalizer done");
    // Scan list removal keeps limits, rejoining resumes alarms
    wr(`SAE_ADDR_SEL, 32'h3);
    wr(`SAE_ADDR_CFG, 32'h80000000 | cw(2'h2, 2'h2, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b0));
    rdg(3'h3, 32'hfffffffa, 1'b1, 1'b0, 2'h0);
    rd(`SAE_ADDR_LOWER, 32'hfffffffb);
    wr(`SAE_ADDR_CFG, 32'h80000000 | cw(2'h2, 2'h2, sae_pkg::SAE_ANALOG, 2'h0, 1'b0, 1'b1));
    rdg(3'h3, 32'hfffffffa, 1'b1, 1'b1, 2'h2);
    // Reconfiguration event disables the alarm and clears limits
    wr(`SAE_ADDR_SEL, 32'h2);
    wr(`SAE_ADDR_EVENT, 32'h2);
    rd(`SAE_ADDR_UPPER, 32'h0);
    rdg(3'h2, 32'd200, 1'b1, 1'b0, 2'h0);
    drain();
    $display("test scan list done");
    repeat (4) @(posedge sys_clk);
    `CHK("notes left", 0, alert_q.size() + store_q.size() + apb_q.size())
    final_report();
  end
endmodule // sae_alarm_evaluator_tb
`default_nettype wire
